//--- hw/qml_adapter.v
// quad asynchronous modem line adapter: bus side, control, and four line engines
// assumes bus strobes and line clock enables are synchronous to clk_sys
`timescale 1ns/1ps
`include "qml_defs.vh"

// ------------------------------------------------------------
// one line: control byte, edge detector, receiver, transmitter
// ------------------------------------------------------------
module qml_line #(
  parameter DBITS = 8,
  parameter STOP2 = 0,
  parameter PAR_EN = 0,
  parameter PAR_ODD = 0
) (
  input wire clk_sys,
  input wire rst,
  input wire tick_a,
  input wire tick_b,
  input wire rxd,
  input wire ctl_in,
  input wire ld_ctrl,
  input wire ld_char,
  input wire clr_ready,
  input wire clr_edge,
  input wire [7:0] bus_byte,
  output reg [7:0] ctrl_r,
  output reg [7:0] rx_char_r,
  output reg ready_r,
  output reg perr_r,
  output reg ferr_r,
  output reg ovr_r,
  output wire tx_buf_empty,
  output wire tx_reg_empty,
  output wire changed,
  output reg txd_r
);
  reg ctl_copy_r;
  reg [7:0] txbuf_r;
  reg txbuf_full_r;
  reg brk_pend_r;
  reg [3:0] rx_ph_r;
  reg [3:0] rx_bit_r;
  reg rx_busy_r;
  reg [8:0] rx_sh_r;
  reg [3:0] tx_ph_r;
  reg [4:0] tx_bit_r;
  reg tx_busy_r;
  reg tx_brk_r;
  reg [11:0] tx_sh_r;
  reg rcv_prev_r;
  wire tick;
  wire par_rx;
  wire [3:0] rx_last;
  wire [4:0] tx_len;
  wire [7:0] mask;
  wire tx_par;
  wire [11:0] tx_frame;
  assign tick = ctrl_r[`QML_CB_SPEED] ? tick_b : tick_a;
  assign changed = ctl_copy_r ^ ctl_in;
  assign tx_buf_empty = ~txbuf_full_r;
  assign tx_reg_empty = ~tx_busy_r;
  assign mask = 8'hff >> (8 - DBITS);
  assign rx_last = DBITS[3:0] + PAR_EN[3:0];
  assign tx_len = 5'd2 + DBITS[4:0] + PAR_EN[4:0] + STOP2[4:0];
  assign par_rx = (^(rx_sh_r[7:0] & mask)) ^ rx_sh_r[DBITS] ^ PAR_ODD[0];
  assign tx_par = (^(txbuf_r & mask)) ^ PAR_ODD[0];
  assign tx_frame = ((12'hfff << (DBITS + 1)) | {3'b000, txbuf_r & mask, 1'b0})
                    & ~({11'h000, (PAR_EN != 0) & ~tx_par} << (DBITS + 1));

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `QML_CB_RESET;
      ctl_copy_r <= 1'b0;
      rcv_prev_r <= 1'b0;
    end else begin
      rcv_prev_r <= ctrl_r[`QML_CB_RCV];
      if (ld_ctrl)
        ctrl_r <= bus_byte;
      if (clr_edge)
        ctl_copy_r <= ctl_in;
    end
  end

  // receiver, sampled mid-bit at 16x
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_ph_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_busy_r <= 1'b0;
      rx_sh_r <= 9'h000;
      rx_char_r <= 8'h00;
      ready_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      if (clr_ready || (ctrl_r[`QML_CB_RCV] && !rcv_prev_r)) begin
        ready_r <= 1'b0;
        ovr_r <= 1'b0;
      end
      if (tick) begin
        if (!rx_busy_r) begin
          if (!rxd) begin
            rx_busy_r <= 1'b1;
            rx_ph_r <= 4'h1;
            rx_bit_r <= 4'h0;
          end
        end else begin
          rx_ph_r <= rx_ph_r + 4'h1;
          if (rx_ph_r == `QML_OVS_HALF - 1) begin
            if (rx_bit_r == 4'h0 && rxd) begin
              rx_busy_r <= 1'b0;
            end else if (rx_bit_r > rx_last) begin
              rx_busy_r <= 1'b0;
              rx_char_r <= rx_sh_r[7:0] & mask;
              perr_r <= (PAR_EN != 0) && par_rx;
              ferr_r <= ~rxd;
              if (ready_r && !clr_ready)
                ovr_r <= 1'b1;
              ready_r <= 1'b1;
            end else begin
              if (rx_bit_r != 4'h0)
                rx_sh_r[rx_bit_r - 4'h1] <= rxd;
              rx_bit_r <= rx_bit_r + 4'h1;
            end
          end
        end
      end
    end
  end

  // transmitter; echo reloads the buffer from the receiver
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txbuf_r <= 8'h00;
      txbuf_full_r <= 1'b0;
      brk_pend_r <= 1'b0;
      tx_ph_r <= 4'h0;
      tx_bit_r <= 5'h00;
      tx_busy_r <= 1'b0;
      tx_brk_r <= 1'b0;
      tx_sh_r <= 12'hfff;
      txd_r <= 1'b1;
    end else begin
      if (!tx_busy_r && txbuf_full_r) begin
        tx_busy_r <= 1'b1;
        tx_brk_r <= brk_pend_r;
        brk_pend_r <= 1'b0;
        txbuf_full_r <= 1'b0;
        tx_ph_r <= 4'h0;
        tx_bit_r <= 5'h00;
        tx_sh_r <= tx_frame;
      end else if (tx_busy_r && tick) begin
        tx_ph_r <= tx_ph_r + 4'h1;
        if (tx_ph_r == `QML_OVS - 1) begin
          tx_sh_r <= {1'b1, tx_sh_r[11:1]};
          tx_bit_r <= tx_bit_r + 5'h01;
          if (tx_bit_r == tx_len - 5'h01)
            tx_busy_r <= 1'b0;
        end
      end
      if (ld_char) begin
        txbuf_r <= bus_byte;
        txbuf_full_r <= 1'b1;
        if (ctrl_r[`QML_CB_RING])
          brk_pend_r <= 1'b1;
      end else if (ctrl_r[`QML_CB_ECHO] && rx_busy_r && tick
                   && rx_ph_r == `QML_OVS_HALF - 1 && rx_bit_r > rx_last) begin
        txbuf_r <= rx_sh_r[7:0] & mask;
        txbuf_full_r <= 1'b1;
      end
      txd_r <= tx_busy_r ? (tx_sh_r[0] & ~tx_brk_r) : 1'b1;
    end
  end
endmodule

// ------------------------------------------------------------
// adapter top: bus decode, scan select, service requests
// ------------------------------------------------------------
module qml_adapter #(
  parameter NLINES = 4,
  parameter DBITS = 8,
  parameter STOP2 = 0,
  parameter PAR_EN = 0,
  parameter PAR_ODD = 0
) (
  input wire clk_sys,
  input wire rst,
  input wire adapter_address_in,
  input wire adapter_address_qualifier,
  input wire write,
  input wire strobe,
  input wire fc_a,
  input wire fc_b,
  input wire scan_count_low,
  input wire scan_count_high,
  input wire [7:0] bus_in,
  input wire [3:0] speed_a_tick,
  input wire [3:0] speed_b_tick,
  input wire [3:0] rxd,
  input wire [3:0] control_in,
  input wire [3:0] ring_in,
  output reg [7:0] bus_out,
  output wire bus_output_enable,
  output wire data_status_select,
  output reg input_data_request,
  output reg output_data_request,
  output reg input_status_request,
  output reg line_fault_flag,
  output reg fault_type_low,
  output reg fault_type_high,
  output wire selected_transmit_mode,
  output wire [3:0] txd,
  output wire [3:0] request_to_send,
  output wire [3:0] terminal_ready,
  output wire [3:0] output_control
);
  wire adapter_enable_one;
  wire [1:0] line_sel;
  wire [3:0] line_select_enable;
  wire [1:0] fc;
  wire [7:0] ctrl [0:3];
  wire [7:0] rxc [0:3];
  wire [3:0] rdy, perr, ferr, ovr, tbe, tre, chg;
  wire [3:0] load_line_control, load_tx_char, clear_rx_ready, clear_edge_detect;
  wire line_active, s_rcv, s_echo, s_ring, s_uflo, output_condition_status;
  wire ring_detect_status, control_input_changed, tx_holding_empty, receive_char_ready;
  wire rd_strobe, underflow, idr_nxt, odr_nxt, sir_nxt, overrun_block, overrun_flag;
  reg ovr_at_req_r;
  reg rcv_seen_r;

  assign adapter_enable_one = adapter_address_in & adapter_address_qualifier;
  assign line_sel = {scan_count_high, scan_count_low};
  assign fc = {fc_a, fc_b};
  genvar g;
  generate
    for (g = 0; g < NLINES; g = g + 1) begin : ln
      assign line_select_enable[g] = adapter_enable_one && (line_sel == g);
      assign load_line_control[g] = line_select_enable[g] && strobe && write
                                    && fc == `QML_FC_CTRL;
      assign load_tx_char[g] = line_select_enable[g] && strobe && write
                               && fc == `QML_FC_DATA;
      assign clear_rx_ready[g] = line_select_enable[g] && rd_strobe && !overrun_block;
      assign clear_edge_detect[g] = (strobe && !(ctrl[g][`QML_CB_XMT] || ctrl[g][`QML_CB_RCV]))
                                    || (line_select_enable[g] && strobe && !write
                                        && input_status_request && !underflow);
      assign request_to_send[g] = ctrl[g][`QML_CB_XMT];
      assign terminal_ready[g] = ctrl[g][`QML_CB_TRDY];
      assign output_control[g] = ctrl[g][`QML_CB_OCTL];
      qml_line #(.DBITS(DBITS), .STOP2(STOP2), .PAR_EN(PAR_EN), .PAR_ODD(PAR_ODD)) u_line (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_a(speed_a_tick[g]),
        .tick_b(speed_b_tick[g]),
        .rxd(rxd[g]),
        .ctl_in(control_in[g]),
        .ld_ctrl(load_line_control[g]),
        .ld_char(load_tx_char[g]),
        .clr_ready(clear_rx_ready[g]),
        .clr_edge(clear_edge_detect[g]),
        .bus_byte(bus_in),
        .ctrl_r(ctrl[g]),
        .rx_char_r(rxc[g]),
        .ready_r(rdy[g]),
        .perr_r(perr[g]),
        .ferr_r(ferr[g]),
        .ovr_r(ovr[g]),
        .tx_buf_empty(tbe[g]),
        .tx_reg_empty(tre[g]),
        .changed(chg[g]),
        .txd_r(txd[g])
      );
    end
  endgenerate

  // scanned line view, only the selected line reaches shared terms
  assign selected_transmit_mode = ctrl[line_sel][`QML_CB_XMT];
  assign s_rcv = ctrl[line_sel][`QML_CB_RCV];
  assign s_echo = ctrl[line_sel][`QML_CB_ECHO];
  assign s_ring = ctrl[line_sel][`QML_CB_RING];
  assign s_uflo = ctrl[line_sel][`QML_CB_UFLO];
  assign line_active = selected_transmit_mode | s_rcv;
  assign receive_char_ready = rdy[line_sel];
  assign tx_holding_empty = tbe[line_sel];
  assign control_input_changed = chg[line_sel];
  assign ring_detect_status = ring_in[line_sel];
  assign overrun_flag = ovr[line_sel];
  assign underflow = s_uflo & tbe[line_sel] & tre[line_sel];
  assign output_condition_status = underflow;

  // request terms
  assign idr_nxt = (receive_char_ready && s_rcv)
                   || (selected_transmit_mode && ferr[line_sel]);
  assign odr_nxt = selected_transmit_mode && !s_echo && !output_condition_status
                   && tx_holding_empty;
  assign sir_nxt = (line_active && control_input_changed)
                   || (s_ring && !selected_transmit_mode && ring_detect_status)
                   || underflow;

  assign rd_strobe = strobe && !write && input_data_request && fc == `QML_FC_DATA;
  assign overrun_block = overrun_flag && !ovr_at_req_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      input_data_request <= 1'b0;
      output_data_request <= 1'b0;
      input_status_request <= 1'b0;
      line_fault_flag <= 1'b0;
      fault_type_low <= 1'b0;
      fault_type_high <= 1'b0;
      ovr_at_req_r <= 1'b0;
      rcv_seen_r <= 1'b0;
    end else begin
      rcv_seen_r <= idr_nxt;
      if (idr_nxt && !rcv_seen_r)
        ovr_at_req_r <= overrun_flag;
      input_data_request <= idr_nxt;
      output_data_request <= odr_nxt && !idr_nxt;
      input_status_request <= sir_nxt && !idr_nxt && !odr_nxt;
      line_fault_flag <= idr_nxt && (perr[line_sel] | ferr[line_sel] | overrun_flag);
      if (overrun_flag) begin
        fault_type_high <= 1'b1;
        fault_type_low <= 1'b1;
      end else begin
        fault_type_high <= ferr[line_sel];
        fault_type_low <= perr[line_sel] & ~ferr[line_sel];
      end
    end
  end

  // bus read path
  assign bus_output_enable = adapter_enable_one && !write && (fc_a == fc_b);
  assign data_status_select = bus_output_enable && fc == `QML_FC_DATA;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      bus_out <= 8'h00;
    else if (fc == `QML_FC_DATA)
      bus_out <= rxc[line_sel];
    else
      bus_out <= {s_ring, s_echo, output_condition_status, 2'b00,
                  ring_detect_status, output_control[line_sel], underflow};
  end
endmodule

//--- hw/qml_defs.vh
// constants for the quad modem line adapter
// assumes inclusion by qml_adapter.v only
`ifndef QML_DEFS_VH
`define QML_DEFS_VH
// line control byte field positions
`define QML_CB_SPEED 0
`define QML_CB_TRDY 1
`define QML_CB_OCTL 2
`define QML_CB_XMT 3
`define QML_CB_RCV 4
`define QML_CB_ECHO 5
`define QML_CB_RING 6
`define QML_CB_UFLO 7
`define QML_CB_RESET 8'h00
// function code pairs (first, second)
`define QML_FC_DATA 2'b00
`define QML_FC_CTRL 2'b01
`define QML_FC_STAT 2'b11
// fault type codes (high, low)
`define QML_FT_PARITY 2'b01
`define QML_FT_FRAME 2'b10
`define QML_FT_OVERRUN 2'b11
// oversampling of the bit clock
`define QML_OVS 16
`define QML_OVS_HALF 8
`endif

//--- verification/qml_adapter_assertions.sv
// checker for the quad line adapter top ports
// assumes one clock domain; bound to every qml_adapter
`timescale 1ns/1ps
module qml_adapter_checker (
  input wire clk_sys,
  input wire rst,
  input wire adapter_address_in,
  input wire adapter_address_qualifier,
  input wire write,
  input wire strobe,
  input wire fc_a,
  input wire fc_b,
  input wire scan_count_low,
  input wire scan_count_high,
  input wire [7:0] bus_in,
  input wire bus_output_enable,
  input wire data_status_select,
  input wire input_data_request,
  input wire output_data_request,
  input wire input_status_request,
  input wire line_fault_flag,
  input wire fault_type_low,
  input wire fault_type_high,
  input wire selected_transmit_mode,
  input wire [3:0] request_to_send,
  input wire [3:0] terminal_ready,
  input wire [3:0] output_control
);
  // ------------------------------------------------------------
  // bus decode, requests, control bytes
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire en = adapter_address_in & adapter_address_qualifier;
  wire [1:0] idx = {scan_count_high, scan_count_low};
  sequence ctl_load;
    strobe && en && write && !fc_a && fc_b;
  endsequence
  a_oe_decode: assert property (bus_output_enable == (en && !write && fc_a == fc_b))
    else $error("bus output enable wrong");
  a_sel_decode: assert property (data_status_select == (bus_output_enable && !fc_a && !fc_b))
    else $error("data select wrong");
  a_req_single: assert property ($onehot0({input_data_request, output_data_request,
    input_status_request})) else $error("more than one request");
  a_ctrl_load: assert property (ctl_load |=>
    {terminal_ready[$past(idx)], output_control[$past(idx)], request_to_send[$past(idx)]}
    == {$past(bus_in[1]), $past(bus_in[2]), $past(bus_in[3])}) else $error("control not applied");
  a_ctrl_hold: assert property (!(strobe && en && write && !fc_a && fc_b) |=>
    $stable({request_to_send, terminal_ready, output_control})) else $error("control changed");
  a_tm_select: assert property (selected_transmit_mode == request_to_send[idx])
    else $error("selected transmit mode wrong");
  a_fault_data: assert property (line_fault_flag |-> input_data_request &&
    {fault_type_high, fault_type_low} != 2'b00) else $error("fault without data request");
  a_odr_xmt: assert property (output_data_request |-> $past(selected_transmit_mode))
    else $error("output request while not transmitting");
endmodule

bind qml_adapter qml_adapter_checker u_chk (.*);

//--- verification/qml_mux_model.sv
// multiplexor unit model driving the adapter bus lines
// assumes the bench calls step; all changes at the falling edge
`timescale 1ns/1ps
module qml_mux_model (
  input wire clk_sys,
  output logic adapter_address_in,
  output logic adapter_address_qualifier,
  output logic write,
  output logic strobe,
  output logic fc_a,
  output logic fc_b,
  output logic scan_count_low,
  output logic scan_count_high,
  output logic [7:0] bus_in
);
  // ------------------------------------------------------------
  // one bus step; a strobe lasts one cycle, then the byte is driven inverted
  // ------------------------------------------------------------
  initial begin
    {adapter_address_in, adapter_address_qualifier, write, strobe} = 4'h0;
    {fc_a, fc_b, scan_count_high, scan_count_low} = 4'h0;
    bus_in = 8'h00;
  end
  task step(input [1:0] en, input w, input [1:0] fc, input stb, input [7:0] b, input [1:0] l);
    @(negedge clk_sys);
    {adapter_address_in, adapter_address_qualifier} = en;
    write = w;
    {fc_a, fc_b} = fc;
    {scan_count_high, scan_count_low} = l;
    strobe = stb;
    bus_in = b;
    if (stb) begin
      @(negedge clk_sys);
      strobe = 1'b0;
      bus_in = ~b;
    end
  endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench for the quad line adapter
// assumes the model drives the bus; the bench drives lines and ticks
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst;
  logic [3:0] rxd, control_in, ring_in;
  wire aa, aq, wr, stb, fa, fb, sl, sh, oe, dss, idr, odr, isr, lff, ftl, fth, stm;
  wire [7:0] bus_in, bus_out;
  wire [3:0] txd, rts, trdy, octl;
  wire [2:0] reqs = {isr, odr, idr};
  int errors, comparisons, i, l, n;
  logic [7:0] b [4];
  logic [7:0] c, got;
  wire [3:0] speed_a_tick = {4{n % 2 == 0}};
  wire [3:0] speed_b_tick = {4{n % 3 == 0}};
  qml_adapter uut (.clk_sys(clk_sys), .rst(rst), .adapter_address_in(aa),
    .adapter_address_qualifier(aq), .write(wr), .strobe(stb), .fc_a(fa), .fc_b(fb),
    .scan_count_low(sl), .scan_count_high(sh), .bus_in(bus_in), .speed_a_tick(speed_a_tick),
    .speed_b_tick(speed_b_tick), .rxd(rxd), .control_in(control_in), .ring_in(ring_in),
    .bus_out(bus_out), .bus_output_enable(oe), .data_status_select(dss),
    .input_data_request(idr), .output_data_request(odr), .input_status_request(isr),
    .line_fault_flag(lff), .fault_type_low(ftl), .fault_type_high(fth),
    .selected_transmit_mode(stm), .txd(txd), .request_to_send(rts), .terminal_ready(trdy),
    .output_control(octl));
  qml_mux_model u_mux (.clk_sys(clk_sys), .adapter_address_in(aa),
    .adapter_address_qualifier(aq), .write(wr), .strobe(stb), .fc_a(fa), .fc_b(fb),
    .scan_count_low(sl), .scan_count_high(sh), .bus_in(bus_in));
  // ------------------------------------------------------------
  // clock, ticks, helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) n <= n + 1;
  function [2:0] pins(input [7:0] v);
    return {v[1], v[2], v[3]};
  endfunction
  function [1:0] dec(input [4:0] k);
    dec[1] = k[4] & k[3] & !k[2] & (k[1] == k[0]);
    dec[0] = dec[1] & !k[1];
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task load(input [1:0] ln, input [7:0] v);
    u_mux.step(2'b11, 1'b1, 2'b01, 1'b1, v, ln);
  endtask
  task send(input [1:0] ln, input [7:0] v, input sb, input int bc);
    logic [9:0] f;
    f = {sb, v, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rxd[ln] = f[k];
      repeat (bc) @(negedge clk_sys);
    end
    rxd[ln] = 1'b1;
  endtask
  task cap(input [1:0] ln, input int bc);
    for (i = 0; i < 3000 && txd[ln] !== 1'b0; i++) @(negedge clk_sys);
    repeat (bc / 2) @(negedge clk_sys);
    for (int k = 0; k < 8; k++) begin
      repeat (bc) @(negedge clk_sys);
      got[k] = txd[ln];
    end
  endtask
  task wait_req(input int k);
    for (i = 0; i < 4000 && reqs[k] !== 1'b1; i++) @(negedge clk_sys);
    check(reqs[k], 1'b1);
  endtask
  initial begin
    #400000;
    errors++;
    give_verdict;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    n = 0;
    rxd = 4'hf;
    control_in = 4'h0;
    ring_in = 4'h0;
    c = $urandom(32'h92f3);
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    check({txd, rts}, 8'hf0);
    for (l = 0; l < 4; l++) begin
      b[l] = $urandom;
      load(l, b[l]);
    end
    u_mux.step(2'b01, 1'b1, 2'b01, 1'b1, ~b[0], 2'd0);
    for (l = 0; l < 4; l++) begin
      u_mux.step(2'b11, 1'b0, 2'b11, 1'b0, 8'h00, l);
      repeat (2) @(negedge clk_sys);
      check({trdy[l], octl[l], rts[l]}, pins(b[l]));
      check(stm, b[l][3]);
      check(bus_out & 8'hd8, {b[l][6], b[l][5], 6'h00});
    end
    for (i = 0; i < 32; i++) begin
      u_mux.step(i[4:3], i[2], i[1:0], 1'b0, 8'h00, 2'd0);
      #1 check({oe, dss}, dec(i[4:0]));
    end
    for (l = 0; l < 4; l++) load(l, 8'h00);
    load(2'd2, 8'h11);
    c = $urandom;
    send(2'd2, c, 1'b1, 48);
    wait_req(0);
    check({lff, fth, ftl}, 3'b000);
    u_mux.step(2'b11, 1'b0, 2'b00, 1'b0, 8'h00, 2'd2);
    repeat (2) @(negedge clk_sys);
    check(bus_out, c);
    u_mux.step(2'b11, 1'b0, 2'b00, 1'b1, 8'h00, 2'd2);
    repeat (2) @(negedge clk_sys);
    check(idr, 1'b0);
    load(2'd1, 8'h08);
    repeat (2) @(negedge clk_sys);
    check(odr, 1'b1);
    c = $urandom;
    u_mux.step(2'b11, 1'b1, 2'b00, 1'b1, c, 2'd1);
    cap(2'd1, 32);
    check(got, c);
    send(2'd1, c, 1'b0, 32);
    wait_req(0);
    check({lff, fth, ftl}, 3'b110);
    u_mux.step(2'b11, 1'b0, 2'b00, 1'b1, 8'h00, 2'd1);
    load(2'd1, 8'h00);
    load(2'd0, 8'h30);
    c = $urandom;
    fork
      send(2'd0, c, 1'b1, 32);
      cap(2'd0, 32);
    join
    check(got, c);
    load(2'd0, 8'h28);
    repeat (2) @(negedge clk_sys);
    check(odr, 1'b0);
    load(2'd2, 8'h48);
    u_mux.step(2'b11, 1'b1, 2'b00, 1'b1, 8'($urandom), 2'd2);
    cap(2'd2, 32);
    check(got, 8'h00);
    load(2'd3, 8'h88);
    wait_req(2);
    check(odr, 1'b0);
    load(2'd3, 8'h10);
    repeat (3) @(negedge clk_sys);
    check(isr, 1'b0);
    control_in[3] = 1'b1;
    wait_req(2);
    u_mux.step(2'b11, 1'b0, 2'b11, 1'b1, 8'h00, 2'd3);
    repeat (2) @(negedge clk_sys);
    check(isr, 1'b0);
    load(2'd3, 8'h40);
    ring_in[3] = 1'b1;
    wait_req(2);
    give_verdict;
  end
endmodule
